// ---- logic/cdss_top.sv ----
// Output dividers, serial clock-stop port and sync pulse generator
`timescale 1ns/1ns
`default_nettype none

module cdss_top (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Divider select pins
    input wire logic I_OSC_POST_DIVIDE_SELECT,
    input wire logic [2:0] I_FEEDBACK_DIVIDE_SELECT,
    input wire logic [1:0] I_BANK_A_DIVIDE_SELECT,
    input wire logic [1:0] I_BANK_B_DIVIDE_SELECT,
    input wire logic [1:0] I_BANK_C_DIVIDE_SELECT,
    // Serial clock-stop port
    input wire logic I_STOP_SER_CLK,
    input wire logic I_STOP_SER_DATA,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [cdss_pkg::ADR_W-1:0] I_WB_ADR,
    input wire logic [cdss_pkg::DAT_W-1:0] I_WB_DAT,
    input wire logic [cdss_pkg::SEL_W-1:0] I_WB_SEL,
    output logic [cdss_pkg::DAT_W-1:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Clock outputs
    output logic [cdss_pkg::BANK_OUTS-1:0] O_BANK_A_OUTPUTS,
    output logic [cdss_pkg::BANK_OUTS-1:0] O_BANK_B_OUTPUTS,
    output logic [cdss_pkg::BANK_OUTS-1:0] O_BANK_C_OUTPUTS,
    output logic O_FEEDBACK_OUTPUT,
    output logic O_SYNC_PULSE_OUT
);
    import cdss_pkg::*;

    function automatic logic [CNT_W-1:0] div_a(input logic [1:0] s);
        case (s)
            2'h0: div_a = 5'h04;
            2'h1: div_a = 5'h06;
            2'h2: div_a = 5'h08;
            default: div_a = 5'h0C;
        endcase
    endfunction : div_a

    function automatic logic [CNT_W-1:0] div_b(input logic [1:0] s);
        case (s)
            2'h0: div_b = 5'h04;
            2'h1: div_b = 5'h06;
            2'h2: div_b = 5'h08;
            default: div_b = 5'h0A;
        endcase
    endfunction : div_b

    function automatic logic [CNT_W-1:0] div_c(input logic [1:0] s);
        case (s)
            2'h0: div_c = 5'h02;
            2'h1: div_c = 5'h04;
            2'h2: div_c = 5'h06;
            default: div_c = 5'h08;
        endcase
    endfunction : div_c

    function automatic logic [CNT_W-1:0] div_fb(input logic [2:0] s);
        case (s)
            3'h0: div_fb = 5'h04;
            3'h1: div_fb = 5'h06;
            3'h2: div_fb = 5'h08;
            3'h3: div_fb = 5'h0A;
            3'h4: div_fb = 5'h0C;
            3'h6: div_fb = 5'h14;
            default: div_fb = 5'h10;
        endcase
    endfunction : div_fb

    // Common period of banks A and C, in post-divided ticks
    function automatic logic [CNT_W-1:0] lcm_ac(input logic [1:0] sa, input logic [1:0] sc);
        case ({sa, sc})
            4'h0, 4'h1: lcm_ac = 5'h04;
            4'h2, 4'h5, 4'hC, 4'hD, 4'hE: lcm_ac = 5'h0C;
            4'h3, 4'h8, 4'h9, 4'hB: lcm_ac = 5'h08;
            4'h4, 4'h6: lcm_ac = 5'h06;
            default: lcm_ac = 5'h18;
        endcase
    endfunction : lcm_ac

    typedef struct packed {
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        logic [CFG_W-1:0] cfg_prev;
        logic sclk_prev;
        logic post_phase;
        logic restart;
        logic pend;
        logic sync_d;
        logic [CNT_W-1:0] cnt_a;
        logic [CNT_W-1:0] cnt_b;
        logic [CNT_W-1:0] cnt_c;
        logic [CNT_W-1:0] cnt_fb;
        logic [CNT_W-1:0] cnt_l;
        cdss_ser_t ser_state;
        logic [3:0] ser_cnt;
        logic [STOP_BITS-1:0] shift;
        logic [STOP_BITS-1:0] enable;
        logic [STOP_BITS-1:0] en_act;
        logic [BANK_OUTS-1:0] out_a;
        logic [BANK_OUTS-1:0] out_b;
        logic [BANK_OUTS-1:0] out_c;
        logic out_fb;
        logic out_sync;
        logic wb_ack;
        logic [DAT_W-1:0] wb_dat;
    } cdss_state_t;

    localparam cdss_state_t ST_RST = '{
        enable: ENABLE_RST,
        en_act: ENABLE_RST,
        ser_state: SER_IDLE,
        restart: 1'b1,
        default: '0
    };

    cdss_state_t st_r;
    cdss_state_t st_nxt;

    always_comb begin
        logic [PIN_W-1:0] pins;
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        logic [1:0] sel_c;
        logic [2:0] sel_fb;
        logic post_two;
        logic tick;
        logic realign;
        logic sclk_rise;
        logic sdata;
        logic [CNT_W-1:0] n_a;
        logic [CNT_W-1:0] n_b;
        logic [CNT_W-1:0] n_c;
        logic [CNT_W-1:0] n_fb;
        logic [CNT_W-1:0] n_l;
        logic [CNT_W-1:0] n_fast;
        logic raw_a;
        logic raw_b;
        logic raw_c;
        logic raw_sync;
        logic [STOP_BITS-1:0] raw;
        logic [STOP_BITS-1:0] act;
        logic wb_req;
        logic pend_now;
        logic hold;
        pins = '0;
        sel_a = '0;
        sel_b = '0;
        sel_c = '0;
        sel_fb = '0;
        post_two = 1'b0;
        tick = 1'b0;
        realign = 1'b0;
        sclk_rise = 1'b0;
        sdata = 1'b0;
        n_a = '0;
        n_b = '0;
        n_c = '0;
        n_fb = '0;
        n_l = '0;
        n_fast = '0;
        raw_a = 1'b0;
        raw_b = 1'b0;
        raw_c = 1'b0;
        raw_sync = 1'b0;
        raw = '0;
        act = '0;
        wb_req = 1'b0;
        pend_now = 1'b0;
        hold = 1'b0;
        st_nxt = st_r;
        pins = {I_OSC_POST_DIVIDE_SELECT, I_FEEDBACK_DIVIDE_SELECT,
                I_BANK_A_DIVIDE_SELECT, I_BANK_B_DIVIDE_SELECT,
                I_BANK_C_DIVIDE_SELECT, I_STOP_SER_CLK, I_STOP_SER_DATA};
        // Pins cross into the oscillator domain through two flops
        st_nxt.pin_s1 = pins;
        st_nxt.pin_s2 = st_r.pin_s1;

        sel_a = st_r.pin_s2[PIN_A_LSB +: 2];
        sel_b = st_r.pin_s2[PIN_B_LSB +: 2];
        sel_c = st_r.pin_s2[PIN_C_LSB +: 2];
        sel_fb = st_r.pin_s2[PIN_FB_LSB +: 3];
        post_two = st_r.pin_s2[PIN_VSEL];
        sdata = st_r.pin_s2[PIN_SDATA];
        sclk_rise = st_r.pin_s2[PIN_SCLK] & ~st_r.sclk_prev;
        st_nxt.sclk_prev = st_r.pin_s2[PIN_SCLK];

        n_fb = div_fb(sel_fb);
        n_a = div_a(sel_a);
        n_b = div_b(sel_b);
        n_c = div_c(sel_c);
        n_l = lcm_ac(sel_a, sel_c);
        n_fast = (n_a < n_c) ? n_a : n_c;

        // tick every cycle, or every other one
        tick = ~post_two | st_r.post_phase;
        st_nxt.post_phase = post_two & ~st_r.post_phase;

        // Any divider change restarts all counters in phase; may cut one period
        pend_now = (st_r.pin_s2[CFG_LSB +: CFG_W] != st_r.cfg_prev) | st_r.restart |
                   st_r.pend;
        // Wait out a sync pulse just begun, so it never lasts one cycle
        hold = st_r.sync_d & ~st_r.out_sync;
        realign = pend_now & ~hold;
        st_nxt.pend = pend_now & hold;
        st_nxt.sync_d = st_r.out_sync;
        st_nxt.cfg_prev = st_r.pin_s2[CFG_LSB +: CFG_W];

        // feedback shares the tick, so the ratio holds
        if (realign) begin
            st_nxt.cnt_a = '0;
            st_nxt.cnt_b = '0;
            st_nxt.cnt_c = '0;
            st_nxt.cnt_fb = '0;
            st_nxt.cnt_l = '0;
            st_nxt.post_phase = 1'b0;
        end else if (tick) begin
            st_nxt.cnt_a = (st_r.cnt_a >= n_a - CNT_ONE) ? '0 : st_r.cnt_a + CNT_ONE;
            st_nxt.cnt_b = (st_r.cnt_b >= n_b - CNT_ONE) ? '0 : st_r.cnt_b + CNT_ONE;
            st_nxt.cnt_c = (st_r.cnt_c >= n_c - CNT_ONE) ? '0 : st_r.cnt_c + CNT_ONE;
            st_nxt.cnt_fb = (st_r.cnt_fb >= n_fb - CNT_ONE) ? '0 : st_r.cnt_fb + CNT_ONE;
            st_nxt.cnt_l = (st_r.cnt_l >= n_l - CNT_ONE) ? '0 : st_r.cnt_l + CNT_ONE;
        end

        // High for the first half of each divided period
        raw_a = st_nxt.cnt_a < (n_a >> 1);
        raw_b = st_nxt.cnt_b < (n_b >> 1);
        raw_c = st_nxt.cnt_c < (n_c >> 1);
        // low in the period before A/C both wrap
        // window spans the faster bank's period
        // common period table covers every pair
        raw_sync = st_nxt.cnt_l < (n_l - n_fast);

        // bit order A0..A3, B0..B3, C1..C3, sync
        raw = {raw_sync, {3{raw_c}}, {BANK_OUTS{raw_b}}, {BANK_OUTS{raw_a}}};
        // gate follows stored bit only while output low
        act = st_r.en_act;
        for (int i = 0; i < STOP_BITS; i++) begin
            if (!raw[i]) begin
                act[i] = st_r.enable[i];
            end
        end
        st_nxt.en_act = act;
        // cleared bit holds the output low
        st_nxt.out_a = raw[EN_A_LSB +: BANK_OUTS] & act[EN_A_LSB +: BANK_OUTS];
        st_nxt.out_b = raw[EN_B_LSB +: BANK_OUTS] & act[EN_B_LSB +: BANK_OUTS];
        // first bank C and feedback are never gated
        st_nxt.out_c = {raw[EN_C_LSB +: 3] & act[EN_C_LSB +: 3], raw_c};
        st_nxt.out_fb = st_nxt.cnt_fb < (n_fb >> 1);
        st_nxt.out_sync = raw[EN_SYNC_BIT] & act[EN_SYNC_BIT];

        // sample data on stop-clock rising edge
        case (st_r.ser_state)
            SER_IDLE: begin
                // low start bit opens a load
                if (sclk_rise && !sdata) begin
                    st_nxt.ser_state = SER_SHIFT;
                    st_nxt.ser_cnt = '0;
                end
            end
            SER_SHIFT: begin
                if (sclk_rise) begin
                    st_nxt.shift[st_r.ser_cnt] = sdata;
                    st_nxt.ser_cnt = st_r.ser_cnt + 4'h1;
                    // full word replaces the enables at once
                    if (st_r.ser_cnt == LAST_BIT) begin
                        st_nxt.enable = st_nxt.shift;
                        st_nxt.ser_state = SER_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.ser_state = SER_IDLE;
            end
        endcase

        // Classic Wishbone: ack one cycle after the request, dropped next
        wb_req = I_WB_CYC & I_WB_STB & ~st_r.wb_ack;
        st_nxt.wb_ack = wb_req;
        st_nxt.wb_dat = '0;
        st_nxt.restart = 1'b0;
        if (wb_req) begin
            if (I_WB_ADR == WB_STATUS_ADR) begin
                st_nxt.wb_dat[PIN_W-1:0] = st_r.pin_s2;
                st_nxt.wb_dat[STAT_BUSY_BIT] = st_r.ser_state == SER_SHIFT;
            end else if (I_WB_ADR == WB_CTRL_ADR) begin
                if (I_WB_WE && I_WB_SEL[0]) begin
                    st_nxt.restart = I_WB_DAT[CTRL_RESTART_BIT];
                end
            end else if (I_WB_ADR == WB_ENABLE_ADR) begin
                st_nxt.wb_dat[STOP_BITS-1:0] = st_r.enable;
                st_nxt.wb_dat[EN_ACT_LSB +: STOP_BITS] = st_r.en_act;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_WB_DAT = st_r.wb_dat;
    assign O_WB_ACK = st_r.wb_ack;
    assign O_BANK_A_OUTPUTS = st_r.out_a;
    assign O_BANK_B_OUTPUTS = st_r.out_b;
    assign O_BANK_C_OUTPUTS = st_r.out_c;
    assign O_FEEDBACK_OUTPUT = st_r.out_fb;
    assign O_SYNC_PULSE_OUT = st_r.out_sync;
endmodule : cdss_top

`default_nettype wire

// ---- logic/cdss_pkg.sv ----
// Constants and types for the clock divider and stop-sync block
package cdss_pkg;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned STOP_BITS = 12;
    localparam int unsigned BANK_OUTS = 4;
    localparam int unsigned PIN_W = 12;
    localparam logic [11:0] ENABLE_RST = 12'hFFF;
    localparam logic [3:0] LAST_BIT = 4'hB;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    // Enable bit positions
    localparam int unsigned EN_A_LSB = 0;
    localparam int unsigned EN_B_LSB = 4;
    localparam int unsigned EN_C_LSB = 8;
    localparam int unsigned EN_SYNC_BIT = 11;
    // Positions inside the synchronised pin vector
    localparam int unsigned PIN_SDATA = 0;
    localparam int unsigned PIN_SCLK = 1;
    localparam int unsigned PIN_C_LSB = 2;
    localparam int unsigned PIN_B_LSB = 4;
    localparam int unsigned PIN_A_LSB = 6;
    localparam int unsigned PIN_FB_LSB = 8;
    localparam int unsigned PIN_VSEL = 11;
    localparam int unsigned CFG_LSB = 2;
    localparam int unsigned CFG_W = 10;
    // Register bus map
    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned SEL_W = 4;
    localparam logic [ADR_W-1:0] WB_STATUS_ADR = 8'h00;
    localparam logic [ADR_W-1:0] WB_CTRL_ADR = 8'h04;
    localparam logic [ADR_W-1:0] WB_ENABLE_ADR = 8'h08;
    localparam int unsigned CTRL_RESTART_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 12;
    localparam int unsigned EN_ACT_LSB = 12;

    typedef enum logic [0:0] {
        SER_IDLE = 1'b0,
        SER_SHIFT = 1'b1
    } cdss_ser_t;
endpackage : cdss_pkg

// ---- dv/cdss_top_monitor.sv ----
// Port checker for the clock divider and stop-sync block
`timescale 1ns/1ns
`default_nettype none

module cdss_top_monitor (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Bus answer
    input wire logic [cdss_pkg::DAT_W-1:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    // Clock outputs
    input wire logic [cdss_pkg::BANK_OUTS-1:0] O_BANK_A_OUTPUTS,
    input wire logic [cdss_pkg::BANK_OUTS-1:0] O_BANK_B_OUTPUTS,
    input wire logic [cdss_pkg::BANK_OUTS-1:0] O_BANK_C_OUTPUTS,
    input wire logic O_FEEDBACK_OUTPUT,
    input wire logic O_SYNC_PULSE_OUT
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    // Bound allows one restart stretching a half period
    a_fb_runs: assert property ($changed(O_FEEDBACK_OUTPUT) |-> ##[1:48]
        $changed(O_FEEDBACK_OUTPUT)) else $error("feedback output stalled");
    a_c0_runs: assert property ($changed(O_BANK_C_OUTPUTS[0]) |-> ##[1:24]
        $changed(O_BANK_C_OUTPUTS[0])) else $error("first bank C output stalled");
    a_a_no_runt: assert property ($rose(O_BANK_A_OUTPUTS[0]) |=>
        O_BANK_A_OUTPUTS[0]) else $error("short high pulse on bank A");
    a_b_no_runt: assert property ($rose(O_BANK_B_OUTPUTS[0]) |=>
        O_BANK_B_OUTPUTS[0]) else $error("short high pulse on bank B");
    // A restart begins every period with all enabled divider outputs high
    a_sync_end_edge: assert property ($rose(O_SYNC_PULSE_OUT) |->
        O_BANK_C_OUTPUTS[0]) else $error("sync ends off a bank C edge");
    a_sync_start_edge: assert property ($fell(O_SYNC_PULSE_OUT) |->
        O_BANK_C_OUTPUTS[0] || O_BANK_A_OUTPUTS[0]) else $error("sync starts off an edge");
    a_sync_min_width: assert property ($fell(O_SYNC_PULSE_OUT) |=>
        !O_SYNC_PULSE_OUT) else $error("sync pulse too short");
    a_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held longer than one cycle");
    a_dat_idle_zero: assert property (!O_WB_ACK |-> O_WB_DAT == '0)
        else $error("read data outside ack cycle");
endmodule : cdss_top_monitor

bind cdss_top cdss_top_monitor mon (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_BANK_A_OUTPUTS(O_BANK_A_OUTPUTS),
    .O_BANK_B_OUTPUTS(O_BANK_B_OUTPUTS), .O_BANK_C_OUTPUTS(O_BANK_C_OUTPUTS),
    .O_FEEDBACK_OUTPUT(O_FEEDBACK_OUTPUT), .O_SYNC_PULSE_OUT(O_SYNC_PULSE_OUT));

`default_nettype wire

// ---- dv/cdss_stop_ctl.sv ----
// Behavioural power-management controller on the serial clock-stop port
`timescale 1ns/1ns
`default_nettype none

module cdss_stop_ctl (
    // Load request
    input wire logic i_go,
    input wire logic [11:0] i_word,
    output logic o_busy,
    // Serial port
    output logic o_sclk,
    output logic o_sdata
);
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b1;
        o_busy = 1'b0;
    end
    always #200 o_sclk = ~o_sclk;
    // start bit first
    // Bits move on the falling edge, stable at every rise
    always begin
        wait (i_go === 1'b1);
        o_busy = 1'b1;
        @(negedge o_sclk) o_sdata = 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(negedge o_sclk) o_sdata = i_word[i];
        end
        @(negedge o_sclk) o_sdata = 1'b1;
        @(negedge o_sclk) o_busy = 1'b0;
        wait (i_go === 1'b0);
    end
endmodule : cdss_stop_ctl

`default_nettype wire

// ---- dv/cdss_top_test.sv ----
// Self-checking bench for the clock divider and stop-sync block
`timescale 1ns/1ns
`default_nettype none

module cdss_top_test;
    import cdss_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, vs = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [2:0] fb = 3'h0;
    logic [1:0] sa = 2'h0, sb = 2'h0, sc = 2'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, q, o_dat;
    logic [11:0] word = 12'hFFF;
    logic ack, sclk, sdata, busy, fbo, sync;
    logic [3:0] qa, qb, qc;
    int errors = 0, checks = 0, ticks = 0;
    int na[4] = '{4, 6, 8, 12};
    int nb[4] = '{4, 6, 8, 10};
    int nc[4] = '{2, 4, 6, 8};
    int nf[8] = '{4, 6, 8, 10, 12, 16, 20, 16};
    int lc[4] = '{4, 12, 24, 24};

    always #25 clk = ~clk;
    cdss_stop_ctl ctl (.i_go(go), .i_word(word), .o_busy(busy), .o_sclk(sclk), .o_sdata(sdata));
    cdss_top dut (.I_CLK(clk), .I_RSTN(rstn), .I_OSC_POST_DIVIDE_SELECT(vs),
        .I_FEEDBACK_DIVIDE_SELECT(fb), .I_BANK_A_DIVIDE_SELECT(sa),
        .I_BANK_B_DIVIDE_SELECT(sb), .I_BANK_C_DIVIDE_SELECT(sc),
        .I_STOP_SER_CLK(sclk), .I_STOP_SER_DATA(sdata), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hF), .O_WB_DAT(o_dat),
        .O_WB_ACK(ack), .O_BANK_A_OUTPUTS(qa), .O_BANK_B_OUTPUTS(qb), .O_BANK_C_OUTPUTS(qc),
        .O_FEEDBACK_OUTPUT(fbo), .O_SYNC_PULSE_OUT(sync));

    task automatic wrap_up;
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %0h seen %0h", n, e, s);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = o_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    function automatic logic sig(input int w);
        logic [4:0] v;
        v = {sync, fbo, qc[0], qb[0], qa[0]};
        return v[w];
    endfunction : sig

    // Length of the next full run at level l, sampled mid-cycle
    task automatic run(input int w, input logic l, output int c);
        c = 0;
        while (sig(w) !== !l) @(negedge clk);
        while (sig(w) !== l) @(negedge clk);
        while (sig(w) === l) begin
            @(negedge clk);
            c++;
        end
    endtask : run

    task automatic t_reg;
        wb(1'b0, WB_STATUS_ADR, 32'h0);
        chk("status", {q[12:2], q[0]}, {1'b0, vs, fb, sa, sb, sc, 1'b1});
        wb(1'b0, WB_ENABLE_ADR, 32'h0);
        chk("enable reset", q, {8'h00, ENABLE_RST, ENABLE_RST});
        wb(1'b1, 8'h0C, 32'hFFFFFFFF);
        wb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, WB_CTRL_ADR, 32'h1);
        wb(1'b0, WB_CTRL_ADR, 32'h0);
        chk("ctrl", q, 32'h0);
    endtask : t_reg

    task automatic t_div;
        int h, l, e;
        for (int v = 0; v < 2; v++) begin
            for (int f = 0; f < 8; f++) begin
                @(posedge clk);
                vs <= v[0];
                fb <= f[2:0];
                sa <= f[1:0];
                sb <= f[1:0];
                sc <= f[1:0];
                repeat (60) @(posedge clk);
                for (int w = 0; w < 4; w++) begin
                    e = w == 0 ? na[f % 4] : w == 1 ? nb[f % 4] : w == 2 ? nc[f % 4] : nf[f];
                    run(w, 1'b1, h);
                    run(w, 1'b0, l);
                    chk("period", h + l, (v + 1) * e);
                end
                run(4, 1'b0, l);
                chk("sync width", l, (v + 1) * nc[f % 4]);
                run(4, 1'b1, h);
                chk("sync period", h + l, (v + 1) * lc[f % 4]);
            end
        end
    endtask : t_div

    // Every bank A / bank C pair
    task automatic t_sync;
        int h, l, m, f;
        for (int a = 0; a < 4; a++) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                vs <= 1'b0;
                sa <= a[1:0];
                sc <= c[1:0];
                repeat (60) @(posedge clk);
                f = na[a] < nc[c] ? na[a] : nc[c];
                m = na[a];
                while (m % nc[c] != 0) m += na[a];
                if (m == f) begin
                    // Coincidence every fast period keeps sync low
                    h = 0;
                    repeat (50) begin
                        @(negedge clk);
                        h = h | sync;
                    end
                    chk("sync held", h, 0);
                end else begin
                    run(4, 1'b0, l);
                    run(4, 1'b1, h);
                    chk("sync width", l, f);
                    chk("sync period", h + l, m);
                end
            end
        end
    endtask : t_sync

    task automatic t_stop(input logic [11:0] w);
        logic [11:0] acc;
        acc = '0;
        @(posedge clk);
        word <= w;
        go <= 1'b1;
        wait (busy === 1'b1);
        @(posedge clk);
        go <= 1'b0;
        wait (busy === 1'b0);
        // Gates wait for each output's low phase
        repeat (60) @(negedge clk);
        repeat (100) begin
            @(negedge clk);
            acc = acc | {sync, qc[3:1], qb, qa};
        end
        chk("running", acc, w);
        wb(1'b0, WB_ENABLE_ADR, 32'h0);
        chk("enable", q, {8'h00, w, w});
    endtask : t_stop

    always @(posedge clk) begin
        ticks++;
        if (ticks > 40000) begin
            errors++;
            wrap_up;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        t_reg;
        t_div;
        t_sync;
        t_stop(12'h8C5);
        t_stop(12'h800);
        t_stop(12'h7FF);
        t_stop(12'hFFF);
        wrap_up;
    end
endmodule : cdss_top_test

`default_nettype wire
